// ===== src/ext_edge_detect.sv
// Synchronises the external interrupt pins and detects the selected edge.
// Assumes asynchronous pins and polarity bits from logic on the same clock.
`timescale 1ns/1ps
module ext_edge_detect
	import irq_regs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic [NUM_EXT-1:0] i_pin,
	input wire logic [NUM_EXT-1:0] i_falling,
	output logic [NUM_EXT-1:0] o_edge
);
	typedef struct packed {
		logic [NUM_EXT-1:0] meta;
		logic [NUM_EXT-1:0] sync;
		logic [NUM_EXT-1:0] prev;
	} edge_state_t;

	edge_state_t st;
	edge_state_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.meta = i_pin;
		next_st.sync = st.meta;
		next_st.prev = st.sync;
	end

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			st <= '0;
		else
			st <= next_st;
	end

	// Falling edge when the polarity bit is one, rising edge otherwise
	genvar g;
	generate
		for (g = 0; g < NUM_EXT; g++)
		begin : g_edge
			assign o_edge[g] = i_falling[g] ? (st.prev[g] & ~st.sync[g])
				: (~st.prev[g] & st.sync[g]);
		end
	endgenerate
endmodule

// ===== src/irq_ctrl_regs.sv
// Control and status registers of the interrupt controller with request arbitration.
// Assumes trap, peripheral and core inputs on i_mclk; external pins are asynchronous.
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
module irq_ctrl_regs
	import irq_regs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [NUM_TRAP-1:0] i_trap,
	input wire logic [NUM_SRC-1:1] i_periph_req,
	input wire logic [NUM_EXT-1:0] i_ext_pin,
	input wire logic i_hold_active,
	input wire logic i_core_level_we,
	input wire logic [3:0] i_core_level,
	output logic [DATA_W-1:0] o_rdata,
	output logic o_irq,
	output logic o_pending,
	output logic [3:0] o_pending_src,
	output logic [3:0] o_cpu_level,
	output logic o_alt_vector,
	output logic [NUM_EXT-1:1] o_ext_edge
);
	typedef struct packed {
		logic [2:0] lvl_low;
		logic lvl_high;
		logic nest_dis;
		logic [NUM_TRAP-1:0] traps;
		logic alt_vec;
		logic [NUM_EXT-1:0] edge_pol;
		logic [NUM_SRC-1:0] flags;
		logic [NUM_SRC-1:0] enables;
		logic [NUM_SRC-1:0][PRIO_W-1:0] prio;
		logic [NUM_EVT-1:0] evt;
		logic [NUM_EVT-1:0] evt_mask;
		logic [DATA_W-1:0] rdata;
		logic irq;
		logic pending;
		logic [3:0] pend_src;
		logic [NUM_EXT-1:1] ext_edge;
	} ctrl_state_t;

	ctrl_state_t st;
	ctrl_state_t next_st;
	logic [NUM_EXT-1:0] ext_edge;

	ext_edge_detect u_edge (
		.i_mclk(i_mclk),
		.i_arst_n(i_arst_n),
		.i_pin(i_ext_pin),
		.i_falling(st.edge_pol),
		.o_edge(ext_edge)
	);

	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] idx);
		hit = (addr == idx);
	endfunction

	// One priority register holds four sources, three bits per nibble
	function automatic logic [DATA_W-1:0] prio_word(input ctrl_state_t s, input int base);
		logic [DATA_W-1:0] w;
		w = '0;
		for (int n = 0; n < 4; n++)
		begin
			if (base + n < NUM_SRC)
				w[n*PRIO_NIB_W +: PRIO_W] = s.prio[base + n];
		end
		prio_word = w;
	endfunction

	logic [NUM_SRC-1:0] set_req;
	logic [3:0] level;

	// Peripheral and trap requests share i_mclk; only the pin path is synchronised
	always_comb
	begin
		set_req = '0;
		set_req[NUM_SRC-1:1] = i_periph_req;
		set_req[SRC_EXT0] = ext_edge[0];
		level = {st.lvl_high, st.lvl_low};
	end

	always_comb
	begin
		logic [DATA_W-1:0] rd;
		logic [NUM_SRC-1:0] cand;
		logic [3:0] sel;
		logic new_pend;
		rd = '0;
		cand = '0;
		sel = NO_SRC;
		new_pend = 1'b0;
		next_st = st;

		// Software writes; unimplemented positions are simply not stored
		if (i_wr)
		begin
			if (hit(i_addr, IDX_STATUS) && !st.nest_dis)
				next_st.lvl_low = i_wdata[LVL_LOW_LSB +: 3];
			if (hit(i_addr, IDX_CORE) && !i_wdata[LVL_HIGH_BIT])
				next_st.lvl_high = 1'b0;
			if (hit(i_addr, IDX_CTL1))
			begin
				next_st.nest_dis = i_wdata[NEST_DIS_BIT];
				next_st.traps = i_wdata[TRAP_LSB +: NUM_TRAP];
			end
			if (hit(i_addr, IDX_CTL2))
			begin
				next_st.alt_vec = i_wdata[ALT_VEC_BIT];
				next_st.edge_pol = i_wdata[POL_LSB +: NUM_EXT];
			end
			if (hit(i_addr, IDX_FLAGS0))
				next_st.flags = i_wdata[NUM_SRC-1:0];
			if (hit(i_addr, IDX_ENABLE0))
				next_st.enables = i_wdata[NUM_SRC-1:0];
			for (int r = 0; r < 4; r++)
			begin
				if (hit(i_addr, IDX_PRIO0 + ADDR_W'(r)))
				begin
					for (int n = 0; n < 4; n++)
					begin
						if (r*4 + n < NUM_SRC)
							next_st.prio[r*4 + n] = i_wdata[n*PRIO_NIB_W +: PRIO_W];
					end
				end
			end
			if (hit(i_addr, IDX_EVT))
				next_st.evt = st.evt & ~i_wdata[NUM_EVT-1:0];
			if (hit(i_addr, IDX_EVT_MASK))
				next_st.evt_mask = i_wdata[NUM_EVT-1:0];
		end

		// Core level update on exception entry and return bypasses the lock
		if (i_core_level_we)
		begin
			next_st.lvl_low = i_core_level[2:0];
			next_st.lvl_high = i_core_level[3];
		end

		// Hardware sets win over a software clear in the same cycle
		next_st.traps = next_st.traps | i_trap;
		next_st.flags = next_st.flags | set_req;
		next_st.ext_edge = ext_edge[NUM_EXT-1:1];

		// Lowest flag position wins among eligible sources
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			cand[i] = st.flags[i] & st.enables[i] && ({1'b0, st.prio[i]} > level);
			if (cand[i])
				sel = 4'(i);
		end
		next_st.pending = |cand;
		next_st.pend_src = sel;
		new_pend = next_st.pending & ~st.pending;

		next_st.evt[NUM_TRAP-1:0] = next_st.evt[NUM_TRAP-1:0] | i_trap;
		next_st.evt[EVT_PEND_BIT] = next_st.evt[EVT_PEND_BIT] | new_pend;
		next_st.irq = |(next_st.evt & next_st.evt_mask);

		// Read data stands only in the cycle after the strobe
		if (i_rd)
		begin
			case (i_addr)
				IDX_STATUS: rd[LVL_LOW_LSB +: 3] = st.lvl_low;
				IDX_CORE: rd[LVL_HIGH_BIT] = st.lvl_high;
				IDX_CTL1:
				begin
					rd[NEST_DIS_BIT] = st.nest_dis;
					rd[TRAP_LSB +: NUM_TRAP] = st.traps;
				end
				IDX_CTL2:
				begin
					rd[ALT_VEC_BIT] = st.alt_vec;
					rd[HOLD_BIT] = i_hold_active;
					rd[POL_LSB +: NUM_EXT] = st.edge_pol;
				end
				IDX_FLAGS0: rd[NUM_SRC-1:0] = st.flags;
				IDX_ENABLE0: rd[NUM_SRC-1:0] = st.enables;
				IDX_PRIO0: rd = prio_word(st, 0);
				IDX_PRIO0 + 4'h1: rd = prio_word(st, 4);
				IDX_PRIO0 + 4'h2: rd = prio_word(st, 8);
				IDX_PRIO3: rd = prio_word(st, 12);
				IDX_EVT: rd[NUM_EVT-1:0] = st.evt;
				IDX_EVT_MASK: rd[NUM_EVT-1:0] = st.evt_mask;
				default: rd = '0;
			endcase
		end
		next_st.rdata = rd;
	end

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st <= '0;
			st.lvl_low <= RST_LVL_LOW;
			st.lvl_high <= RST_LVL_HIGH;
			st.nest_dis <= RST_NEST_DIS;
			st.traps <= RST_TRAPS;
			st.alt_vec <= RST_ALT_VEC;
			st.edge_pol <= RST_POL;
			st.flags <= RST_FLAGS;
			st.enables <= RST_ENABLES;
			st.prio <= {NUM_SRC{RST_PRIO}};
			st.evt <= RST_EVT;
			st.evt_mask <= RST_EVT_MASK;
			st.pend_src <= NO_SRC;
		end
		else
			st <= next_st;
	end

	assign o_rdata = st.rdata;
	assign o_irq = st.irq;
	assign o_pending = st.pending;
	assign o_pending_src = st.pend_src;
	assign o_cpu_level = {st.lvl_high, st.lvl_low};
	assign o_alt_vector = st.alt_vec;
	assign o_ext_edge = st.ext_edge;

	// Checks sample on i_mclk and rest while reset is asserted
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);

	sequence sw_status_write;
		i_wr && hit(i_addr, IDX_STATUS) && !i_core_level_we;
	endsequence

	sequence read_ctl2;
		i_rd && hit(i_addr, IDX_CTL2);
	endsequence

	level_lock_a: assert property (
		(sw_status_write and st.nest_dis) |=> o_cpu_level[2:0] == $past(o_cpu_level[2:0])
	) else $error("level field changed while nesting disabled");

	level_open_a: assert property (
		(sw_status_write and !st.nest_dis) |=> o_cpu_level[2:0] == $past(i_wdata[7:5])
	) else $error("level field not written");

	high_bit_set_a: assert property (
		(!i_core_level_we && !o_cpu_level[3]) |=> !o_cpu_level[3]
	) else $error("level bit 3 set by software");

	trap_set_a: assert property (
		(i_trap != '0) |=> (st.traps & $past(i_trap)) == $past(i_trap)
	) else $error("trap flag not set");

	flag_set_a: assert property (
		(i_periph_req != '0) |=> (st.flags[NUM_SRC-1:1] & $past(i_periph_req)) == $past(i_periph_req)
	) else $error("request flag not set");

	hold_read_a: assert property (
		(read_ctl2 ##0 i_hold_active) |=> o_rdata[HOLD_BIT]
	) else $error("hold status misread");

	core_read_a: assert property (
		(i_rd && hit(i_addr, IDX_CORE)) |=> o_rdata == {12'h000, $past(o_cpu_level[3]), 3'h0}
	) else $error("core control read wrong");

	status_zero_a: assert property (
		(i_rd && hit(i_addr, IDX_STATUS)) |=> o_rdata[15:8] == 8'h00 && o_rdata[4:0] == 5'h00
	) else $error("unimplemented status bits nonzero");

	pending_cause_a: assert property (
		o_pending |-> |(($past(st.flags & st.enables) >> o_pending_src) & NUM_SRC'(1))
	) else $error("pending without flagged source");

	level_block_a: assert property (
		(o_cpu_level[2:0] == 3'h7) [*2] |-> !o_pending
	) else $error("pending at top level");

	// Read data stands for one cycle, then returns to zero
	rdata_idle_a: assert property (
		!i_rd |=> o_rdata == '0
	) else $error("read data outside its cycle");

	status_read_a: assert property (
		(i_rd && hit(i_addr, IDX_STATUS)) |=> o_rdata[7:5] == $past(o_cpu_level[2:0])
	) else $error("status level read wrong");

	// Unimplemented positions read as zero
	ctl1_zero_a: assert property (
		(i_rd && hit(i_addr, IDX_CTL1)) |=> o_rdata[14:7] == 8'h00 && !o_rdata[0]
	) else $error("unimplemented control one bits nonzero");

	ctl2_zero_a: assert property (
		read_ctl2 |=> o_rdata[13:5] == 9'h000
	) else $error("unimplemented control two bits nonzero");

	flags_zero_a: assert property (
		(i_rd && hit(i_addr, IDX_FLAGS0)) |=> !o_rdata[DATA_W-1]
	) else $error("unimplemented flag bit nonzero");

	// Sticky bits only fall on a software write
	flag_sticky_a: assert property (
		!(i_wr && hit(i_addr, IDX_FLAGS0)) |=> (st.flags & $past(st.flags)) == $past(st.flags)
	) else $error("request flag cleared by hardware");

	trap_sticky_a: assert property (
		!(i_wr && hit(i_addr, IDX_CTL1)) |=> (st.traps & $past(st.traps)) == $past(st.traps)
	) else $error("trap flag cleared by hardware");

	ext_flag_a: assert property (
		ext_edge[SRC_EXT0] |=> st.flags[SRC_EXT0]
	) else $error("external edge did not set its flag");

	// Control fields follow the last write or core update
	nest_write_a: assert property (
		(i_wr && hit(i_addr, IDX_CTL1)) |=> st.nest_dis == $past(i_wdata[NEST_DIS_BIT])
	) else $error("nesting disable not written");

	alt_vector_a: assert property (
		(i_wr && hit(i_addr, IDX_CTL2)) |=> o_alt_vector == $past(i_wdata[ALT_VEC_BIT])
	) else $error("vector table select not written");

	core_level_a: assert property (
		i_core_level_we |=> o_cpu_level == $past(i_core_level)
	) else $error("core level update lost");

	// Nothing pending leaves the source index at its idle code
	idle_source_a: assert property (
		!o_pending |-> o_pending_src == NO_SRC
	) else $error("source index without pending request");
endmodule

// ===== src/irq_regs_pkg.sv
// Constants shared by the interrupt controller register set.
// Assumes a single 200 MHz clock and a 4-bit register index on the plain port.
package irq_regs_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam int NUM_SRC = 15;
	localparam int NUM_TRAP = 6;
	localparam int NUM_EXT = 5;
	localparam int NUM_EVT = 7;

	// Register indices
	localparam logic [ADDR_W-1:0] IDX_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] IDX_CORE = 4'h1;
	localparam logic [ADDR_W-1:0] IDX_CTL1 = 4'h2;
	localparam logic [ADDR_W-1:0] IDX_CTL2 = 4'h3;
	localparam logic [ADDR_W-1:0] IDX_FLAGS0 = 4'h4;
	localparam logic [ADDR_W-1:0] IDX_ENABLE0 = 4'h5;
	localparam logic [ADDR_W-1:0] IDX_PRIO0 = 4'h6;
	localparam logic [ADDR_W-1:0] IDX_PRIO3 = 4'h9;
	localparam logic [ADDR_W-1:0] IDX_EVT = 4'ha;
	localparam logic [ADDR_W-1:0] IDX_EVT_MASK = 4'hb;

	// Field positions
	localparam int LVL_LOW_LSB = 5;
	localparam int LVL_HIGH_BIT = 3;
	localparam int NEST_DIS_BIT = 15;
	localparam int TRAP_LSB = 1;
	localparam int ALT_VEC_BIT = 15;
	localparam int HOLD_BIT = 14;
	localparam int POL_LSB = 0;
	localparam int PRIO_NIB_W = 4;
	localparam int PRIO_W = 3;
	localparam int EVT_PEND_BIT = 6;

	// Reset values
	localparam logic [2:0] RST_LVL_LOW = 3'h0;
	localparam logic RST_LVL_HIGH = 1'b0;
	localparam logic RST_NEST_DIS = 1'b0;
	localparam logic [NUM_TRAP-1:0] RST_TRAPS = 6'h00;
	localparam logic RST_ALT_VEC = 1'b0;
	localparam logic [NUM_EXT-1:0] RST_POL = 5'h00;
	localparam logic [NUM_SRC-1:0] RST_FLAGS = 15'h0000;
	localparam logic [NUM_SRC-1:0] RST_ENABLES = 15'h0000;
	localparam logic [PRIO_W-1:0] RST_PRIO = 3'h4;
	localparam logic [NUM_EVT-1:0] RST_EVT = 7'h00;
	localparam logic [NUM_EVT-1:0] RST_EVT_MASK = 7'h00;

	// Flag register source positions
	localparam int SRC_EXT0 = 0;
	localparam int SRC_CAPTURE1 = 1;
	localparam int SRC_COMPARE1 = 2;
	localparam int SRC_TIMER1 = 3;
	localparam int SRC_DMA_CH0 = 4;
	localparam int SRC_CAPTURE2 = 5;
	localparam int SRC_COMPARE2 = 6;
	localparam int SRC_TIMER2 = 7;
	localparam int SRC_TIMER3 = 8;
	localparam int SRC_SPI1_ERROR = 9;
	localparam int SRC_SPI1_EVENT = 10;
	localparam int SRC_UART1_RX = 11;
	localparam int SRC_UART1_TX = 12;
	localparam int SRC_ADC1_DONE = 13;
	localparam int SRC_DMA_CH1 = 14;
	localparam logic [3:0] NO_SRC = 4'hf;
endpackage

// ===== tb/interrupt_ctrl_status_regs_tb.sv
// Self-checking bench for the interrupt controller register set.
// Assumes the source model drives all core and request inputs.
`timescale 1ns/1ps
module interrupt_ctrl_status_regs_tb;
	import irq_regs_pkg::*;
	logic mclk, arst_n, wr, rd, irq, pending, altv, hold, lwe;
	logic [3:0] addr, psrc, level, lvl;
	logic [15:0] wdata, rdata;
	logic [5:0] trap;
	logic [14:1] preq;
	logic [4:0] pin;
	logic [4:1] ext_edge;
	int fails = 0;
	int tests_run = 0;
	irq_src_model u_src (.i_mclk(mclk), .o_trap(trap), .o_req(preq), .o_pin(pin),
		.o_hold(hold), .o_lvl_we(lwe), .o_lvl(lvl));
	irq_ctrl_regs u_dut (.i_mclk(mclk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .i_trap(trap), .i_periph_req(preq), .i_ext_pin(pin),
		.i_hold_active(hold), .i_core_level_we(lwe), .i_core_level(lvl), .o_rdata(rdata),
		.o_irq(irq), .o_pending(pending), .o_pending_src(psrc), .o_cpu_level(level),
		.o_alt_vector(altv), .o_ext_edge(ext_edge));
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic final_report;
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic out_chk(input logic [15:0] exp);
		repeat (2) @(posedge mclk);
		#1;
		chk({11'h000, pending, psrc}, exp);
	endtask
	initial
	begin
		#100000;
		fails++;
		final_report();
	end
	initial
	begin
		arst_n = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		for (int i = 0; i < 5; i++)
			rd_chk(4'(i), 16'h0000);
		rd_chk(4'hc, 16'h0000);
		wr_reg(IDX_STATUS, 16'hffff);
		rd_chk(IDX_STATUS, 16'h00e0);
		chk({12'h000, level}, 16'h0007);
		wr_reg(IDX_CORE, 16'hffff);
		rd_chk(IDX_CORE, 16'h0000);
		u_src.set_level(4'hb);
		rd_chk(IDX_CORE, 16'h0008);
		rd_chk(IDX_STATUS, 16'h0060);
		chk({12'h000, level}, 16'h000b);
		wr_reg(IDX_CORE, 16'h0000);
		rd_chk(IDX_CORE, 16'h0000);
		wr_reg(IDX_CTL1, 16'hffff);
		rd_chk(IDX_CTL1, 16'h807e);
		wr_reg(IDX_STATUS, 16'h0000);
		rd_chk(IDX_STATUS, 16'h0060);
		wr_reg(IDX_CTL1, 16'h0000);
		wr_reg(IDX_STATUS, 16'h0000);
		rd_chk(IDX_STATUS, 16'h0000);
		for (int i = 0; i < 6; i++)
		begin
			u_src.pulse(1'b1, i);
			rd_chk(IDX_CTL1, 16'h0002 << i);
			wr_reg(IDX_CTL1, 16'h0000);
		end
		// Masked event stays quiet, unmasked one raises the line until cleared
		wr_reg(IDX_EVT, 16'h003f);
		wr_reg(IDX_EVT_MASK, 16'h0001);
		u_src.pulse(1'b1, 1);
		repeat (3) @(posedge mclk);
		#1;
		chk({15'h0000, irq}, 16'h0000);
		u_src.pulse(1'b1, 0);
		repeat (3) @(posedge mclk);
		#1;
		chk({15'h0000, irq}, 16'h0001);
		wr_reg(IDX_EVT, 16'h0003);
		repeat (2) @(posedge mclk);
		#1;
		chk({15'h0000, irq}, 16'h0000);
		wr_reg(IDX_CTL2, 16'hffff);
		rd_chk(IDX_CTL2, 16'h801f);
		chk({15'h0000, altv}, 16'h0001);
		u_src.set_hold(1'b1);
		rd_chk(IDX_CTL2, 16'hc01f);
		u_src.set_hold(1'b0);
		wr_reg(IDX_FLAGS0, 16'h0000);
		u_src.set_pin(0, 1'b1);
		repeat (6) @(posedge mclk);
		rd_chk(IDX_FLAGS0, 16'h0000);
		u_src.set_pin(0, 1'b0);
		repeat (6) @(posedge mclk);
		rd_chk(IDX_FLAGS0, 16'h0001);
		wr_reg(IDX_CTL2, 16'h0000);
		#1;
		chk({15'h0000, altv}, 16'h0000);
		// Rising edge on pin 1 gives one pulse on the edge output
		u_src.set_pin(1, 1'b1);
		repeat (3) @(posedge mclk);
		#1;
		chk({12'h000, ext_edge}, 16'h0001);
		@(posedge mclk);
		#1;
		chk({12'h000, ext_edge}, 16'h0000);
		wr_reg(IDX_FLAGS0, 16'h0000);
		u_src.set_pin(0, 1'b1);
		repeat (6) @(posedge mclk);
		rd_chk(IDX_FLAGS0, 16'h0001);
		wr_reg(IDX_FLAGS0, 16'h0000);
		for (int k = 1; k < 15; k++)
		begin
			u_src.pulse(1'b0, k);
			rd_chk(IDX_FLAGS0, (16'hffff >> (15 - k)) & 16'hfffe);
		end
		repeat (10) @(posedge mclk);
		rd_chk(IDX_FLAGS0, 16'h7ffe);
		wr_reg(IDX_FLAGS0, 16'hffff);
		rd_chk(IDX_FLAGS0, 16'h7fff);
		wr_reg(IDX_FLAGS0, 16'h0000);
		wr_reg(IDX_ENABLE0, 16'h0008);
		u_src.pulse(1'b0, 3);
		out_chk(16'h0013);
		// A newly pending request raises the line once unmasked
		wr_reg(IDX_EVT_MASK, 16'h0040);
		#1;
		chk({15'h0000, irq}, 16'h0001);
		wr_reg(IDX_EVT, 16'h0040);
		#1;
		chk({15'h0000, irq}, 16'h0000);
		wr_reg(IDX_STATUS, 16'h0080);
		out_chk(16'h000f);
		wr_reg(IDX_PRIO0, 16'hffff);
		rd_chk(IDX_PRIO0, 16'h7777);
		wr_reg(IDX_PRIO0, 16'h6000);
		out_chk(16'h0013);
		wr_reg(IDX_STATUS, 16'h0060);
		out_chk(16'h0013);
		u_src.set_level(4'h8);
		out_chk(16'h000f);
		final_report();
	end
endmodule

// ===== tb/irq_src_model.sv
// Model of the CPU core and the request sources around the interrupt registers.
// Assumes the bench calls its tasks; outputs change just after a rising edge.
`timescale 1ns/1ps
module irq_src_model (
	input wire logic i_mclk,
	output logic [5:0] o_trap,
	output logic [14:1] o_req,
	output logic [4:0] o_pin,
	output logic o_hold,
	output logic o_lvl_we,
	output logic [3:0] o_lvl
);
	initial
	begin
		o_trap = 6'h00;
		o_req = 14'h0000;
		o_pin = 5'h00;
		o_hold = 1'b0;
		o_lvl_we = 1'b0;
		o_lvl = 4'h0;
	end
	// One-cycle request from a trap or a peripheral
	task automatic pulse(input logic trap, input int k);
		@(posedge i_mclk);
		if (trap)
			o_trap[k] <= 1'b1;
		else
			o_req[k] <= 1'b1;
		@(posedge i_mclk);
		o_trap <= 6'h00;
		o_req <= 14'h0000;
	endtask
	task automatic set_pin(input int k, input logic v);
		@(posedge i_mclk);
		o_pin[k] <= v;
	endtask
	task automatic set_hold(input logic v);
		@(posedge i_mclk);
		o_hold <= v;
	endtask
	// Exception entry or return moves the level
	task automatic set_level(input logic [3:0] v);
		@(posedge i_mclk);
		o_lvl <= v;
		o_lvl_we <= 1'b1;
		@(posedge i_mclk);
		o_lvl_we <= 1'b0;
	endtask
endmodule
